/* File: inc/gpio_function_config_pkg.sv */
package gpio_function_config_pkg;

  // ------------------------------------------------------------
  // register map (printed offsets are indexes, byte address = 4x)
  // ------------------------------------------------------------
  localparam logic [15:0] PIN_CONFIG_A_INDEX = 16'h000E;
  localparam logic [15:0] PIN_CONFIG_B_INDEX = 16'h000F;
  localparam logic [15:0] PIN_CONFIG_C_INDEX = 16'h0010;
  localparam logic [15:0] PIN_CONFIG_D_INDEX = 16'h0011;
  localparam logic [15:0] CURRENT_RESULT_UPPER_INDEX = 16'h0020;
  localparam logic [15:0] CURRENT_RESULT_LOWER_INDEX = 16'h0021;
  localparam logic [15:0] EVENT_STATUS_INDEX = 16'h0022;
  localparam logic [15:0] EVENT_MASK_INDEX = 16'h0023;
  localparam logic [15:0] CONTROL_INDEX = 16'h0024;
  localparam logic [15:0] PIN_INPUT_INDEX = 16'h0025;
  localparam logic [15:0] SPI_DATA_INDEX = 16'h0026;
  localparam logic [1:0] BYTE_ADDR_SHIFT = 2'h2;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int HI_FIELD_LSB = 3;
  localparam int LO_FIELD_LSB = 0;
  localparam int FAULT_IN_ENABLE_BIT = 7;
  localparam int SPI_MASTER_ENABLE_BIT = 6;
  localparam int CONV_DONE_ENABLE_BIT = 6;
  localparam int BALANCE_ENABLE_BIT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_A_WMASK = 8'hFF;
  localparam logic [7:0] CONFIG_B_WMASK = 8'h7F;
  localparam logic [7:0] CONFIG_CD_WMASK = 8'h3F;
  localparam int EVT_CONV_DONE = 0;
  localparam int EVT_FAULT_IN = 1;
  localparam int EVT_SPI_DONE = 2;
  localparam int NUM_EVENTS = 3;
  localparam int NUM_PINS = 8;
  localparam logic [7:0] SPI_HALF_PERIOD = 8'h04;
  localparam logic [3:0] SPI_BITS = 4'h8;

  // ------------------------------------------------------------
  // pin function codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_HIGH_Z = 3'h0,
    FN_ANALOG_TEMP = 3'h1,
    FN_ANALOG_ONLY = 3'h2,
    FN_DIGITAL_IN = 3'h3,
    FN_DRIVE_HIGH = 3'h4,
    FN_DRIVE_LOW = 3'h5,
    FN_ANALOG_PULLUP = 3'h6,
    FN_ANALOG_PULLDOWN = 3'h7
  } pin_function_type;

  // per-pin controls handed to the pad
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
    logic analog_en;
    logic temp_cmp_en;
    logic digital_in_en;
  } pad_ctrl_type;

  typedef struct packed {
    logic [15:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

endpackage : gpio_function_config_pkg

/* File: src/pin_function_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_function_decode (
  // configuration
  input wire logic [2:0] function_i,
  // pad controls
  output gpio_function_config_pkg::pad_ctrl_type pad_o
);
  gpio_function_config_pkg::pin_function_type fn;

  always_comb begin
    fn = gpio_function_config_pkg::pin_function_type'(function_i);
    pad_o = '0;
    pad_o.oe_n = 1'b1;
    case (fn)
      gpio_function_config_pkg::FN_HIGH_Z: begin
        pad_o.oe_n = 1'b1;
      end
      gpio_function_config_pkg::FN_ANALOG_TEMP: begin
        pad_o.analog_en = 1'b1;
        pad_o.temp_cmp_en = 1'b1;
      end
      gpio_function_config_pkg::FN_ANALOG_ONLY: begin
        pad_o.analog_en = 1'b1;
      end
      gpio_function_config_pkg::FN_DIGITAL_IN: begin
        pad_o.digital_in_en = 1'b1;
      end
      gpio_function_config_pkg::FN_DRIVE_HIGH: begin
        pad_o.out = 1'b1;
        pad_o.oe_n = 1'b0;
      end
      gpio_function_config_pkg::FN_DRIVE_LOW: begin
        pad_o.oe_n = 1'b0;
      end
      gpio_function_config_pkg::FN_ANALOG_PULLUP: begin
        pad_o.analog_en = 1'b1;
        pad_o.pull_up = 1'b1;
      end
      gpio_function_config_pkg::FN_ANALOG_PULLDOWN: begin
        pad_o.analog_en = 1'b1;
        pad_o.pull_down = 1'b1;
      end
      default: begin
        pad_o.oe_n = 1'b1;
      end
    endcase
  end
endmodule : pin_function_decode
`default_nettype wire

/* File: src/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [7:0] async_i,
  output logic [7:0] sync_o
);
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  always_comb begin
    state_next.first = async_i;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.second;
endmodule : pin_sync
`default_nettype wire

/* File: src/gpio_function_config.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module gpio_function_config (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic [15:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // current sense
  input wire logic CONV_DONE_I,
  input wire logic [15:0] CURRENT_RESULT_I,
  input wire logic BALANCE_DRIVE_I,
  // pins
  input wire logic [7:0] PIN_IN_I,
  output logic [7:0] PIN_OUT_O,
  output logic [7:0] PIN_OE_N_O,
  output logic [7:0] PIN_PULL_UP_O,
  output logic [7:0] PIN_PULL_DOWN_O,
  output logic [7:0] PIN_ANALOG_EN_O,
  output logic [7:0] PIN_TEMP_CMP_EN_O,
  output logic [7:0] PIN_DIGITAL_IN_EN_O,
  // alarm and interrupt
  output logic ALARM_OUTPUT_N_O,
  output logic IRQ_O
);
  typedef enum logic [1:0] {SPI_IDLE, SPI_LOW, SPI_HIGH} spi_state_type;

  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] cfg_c;
    logic [7:0] cfg_d;
    logic [7:0] control;
    logic [2:0] status;
    logic [2:0] mask;
    logic conv_done_n;
    logic conv_prev;
    logic [15:0] current_result;
    spi_state_type spi_state;
    logic [7:0] spi_timer;
    logic [3:0] spi_count;
    logic [7:0] spi_shift;
    logic spi_sclk;
    logic spi_cs_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    gpio_function_config_pkg::pad_ctrl_type [7:0] pads;
    logic alarm_n;
    logic irq;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [7:0] pin_sync;
  logic [23:0] fields;
  gpio_function_config_pkg::pad_ctrl_type [7:0] decoded;
  logic [15:0] index;
  logic access;
  logic wr;
  logic rd;

  pin_sync pin_sync_inst (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .async_i(PIN_IN_I),
    .sync_o(pin_sync)
  );

  // ------------------------------------------------------------
  // per-pin decode
  // ------------------------------------------------------------
  // field layout
  assign fields = {state_reg.cfg_d[5:0], state_reg.cfg_c[5:0], state_reg.cfg_b[5:0],
                   state_reg.cfg_a[5:0]};

  genvar g;
  generate
    for (g = 0; g < gpio_function_config_pkg::NUM_PINS; g++) begin : g_pin
      pin_function_decode decode_inst (
        .function_i(fields[3*g +: 3]),
        .pad_o(decoded[g])
      );
    end
  endgenerate

  assign index = PADDR_I >> gpio_function_config_pkg::BYTE_ADDR_SHIFT;
  // no-wait-state answer: access phase completes in its first cycle, pready registered high from setup
  assign access = PSEL_I && PENABLE_I && state_reg.pready;
  assign wr = access && PWRITE_I;
  assign rd = access && !PWRITE_I;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] events;
    logic conv_edge;
    logic spi_on;
    logic mapped;
    logic [31:0] rdata;
    events = '0;
    conv_edge = 1'b0;
    spi_on = 1'b0;
    mapped = 1'b1;
    rdata = '0;
    state_next = state_reg;

    state_next.pready = PSEL_I && !PENABLE_I;
    state_next.pslverr = 1'b0;
    state_next.current_result = CURRENT_RESULT_I;

    // register read data and unmapped detection
    case (index)
      gpio_function_config_pkg::PIN_CONFIG_A_INDEX: rdata = {24'h00_0000, state_reg.cfg_a};
      gpio_function_config_pkg::PIN_CONFIG_B_INDEX: rdata = {24'h00_0000, state_reg.cfg_b};
      gpio_function_config_pkg::PIN_CONFIG_C_INDEX: rdata = {24'h00_0000, state_reg.cfg_c};
      gpio_function_config_pkg::PIN_CONFIG_D_INDEX: rdata = {24'h00_0000, state_reg.cfg_d};
      gpio_function_config_pkg::CURRENT_RESULT_UPPER_INDEX: begin
        rdata = {24'h00_0000, state_reg.current_result[15:8]};
      end
      gpio_function_config_pkg::CURRENT_RESULT_LOWER_INDEX: begin
        rdata = {24'h00_0000, state_reg.current_result[7:0]};
      end
      gpio_function_config_pkg::EVENT_STATUS_INDEX: rdata = {29'h0000_0000, state_reg.status};
      gpio_function_config_pkg::EVENT_MASK_INDEX: rdata = {29'h0000_0000, state_reg.mask};
      gpio_function_config_pkg::CONTROL_INDEX: rdata = {24'h00_0000, state_reg.control};
      gpio_function_config_pkg::PIN_INPUT_INDEX: rdata = {24'h00_0000, pin_sync};
      gpio_function_config_pkg::SPI_DATA_INDEX: rdata = {24'h00_0000, state_reg.spi_shift};
      default: mapped = 1'b0;
    endcase
    // latched in setup so the answer stands beside pready
    if (PSEL_I && !PENABLE_I) begin
      state_next.prdata = PWRITE_I ? 32'h0000_0000 : rdata;
      state_next.pslverr = !mapped;
    end

    if (wr) begin
      case (index)
        gpio_function_config_pkg::PIN_CONFIG_A_INDEX: begin
          state_next.cfg_a = PWDATA_I[7:0] & gpio_function_config_pkg::CONFIG_A_WMASK;
        end
        gpio_function_config_pkg::PIN_CONFIG_B_INDEX: begin
          state_next.cfg_b = PWDATA_I[7:0] & gpio_function_config_pkg::CONFIG_B_WMASK;
        end
        gpio_function_config_pkg::PIN_CONFIG_C_INDEX: begin
          state_next.cfg_c = PWDATA_I[7:0] & gpio_function_config_pkg::CONFIG_CD_WMASK;
        end
        gpio_function_config_pkg::PIN_CONFIG_D_INDEX: begin
          state_next.cfg_d = PWDATA_I[7:0] & gpio_function_config_pkg::CONFIG_CD_WMASK;
        end
        gpio_function_config_pkg::EVENT_MASK_INDEX: state_next.mask = PWDATA_I[2:0];
        gpio_function_config_pkg::CONTROL_INDEX: state_next.control = PWDATA_I[7:0];
        gpio_function_config_pkg::SPI_DATA_INDEX: begin
          if (state_reg.spi_state == SPI_IDLE) begin
            state_next.spi_shift = PWDATA_I[7:0];
            state_next.spi_count = gpio_function_config_pkg::SPI_BITS;
          end
        end
        default: state_next.prdata = state_next.prdata;
      endcase
    end

    // ----------------------------------------------------------
    // conversion-done strobe on pin 1
    // ----------------------------------------------------------
    conv_edge = CONV_DONE_I && !state_reg.conv_prev;
    state_next.conv_prev = CONV_DONE_I;
    if (state_reg.cfg_b[gpio_function_config_pkg::CONV_DONE_ENABLE_BIT] && conv_edge) begin
      state_next.conv_done_n = 1'b0;
    end else if (rd && index == gpio_function_config_pkg::CURRENT_RESULT_UPPER_INDEX) begin
      state_next.conv_done_n = 1'b1;
    end
    if (conv_edge) begin
      events[gpio_function_config_pkg::EVT_CONV_DONE] = 1'b1;
    end

    // ----------------------------------------------------------
    // spi master (mode 0, msb first)
    // ----------------------------------------------------------
    // enable
    spi_on = state_reg.cfg_a[gpio_function_config_pkg::SPI_MASTER_ENABLE_BIT];
    state_next.spi_timer = state_reg.spi_timer + 8'h01;
    case (state_reg.spi_state)
      SPI_IDLE: begin
        state_next.spi_sclk = 1'b0;
        state_next.spi_cs_n = 1'b1;
        state_next.spi_timer = '0;
        if (spi_on && state_next.spi_count != 4'h0) begin
          state_next.spi_cs_n = 1'b0;
          state_next.spi_state = SPI_LOW;
        end
      end
      SPI_LOW: begin
        if (state_reg.spi_timer == gpio_function_config_pkg::SPI_HALF_PERIOD) begin
          state_next.spi_timer = '0;
          state_next.spi_sclk = 1'b1;
          state_next.spi_state = SPI_HIGH;
        end
      end
      SPI_HIGH: begin
        if (state_reg.spi_timer == gpio_function_config_pkg::SPI_HALF_PERIOD) begin
          state_next.spi_timer = '0;
          state_next.spi_sclk = 1'b0;
          // miso on pin 5 sampled, shifted in
          state_next.spi_shift = {state_reg.spi_shift[6:0], pin_sync[4]};
          state_next.spi_count = state_reg.spi_count - 4'h1;
          state_next.spi_state = (state_reg.spi_count == 4'h1) ? SPI_IDLE : SPI_LOW;
          if (state_reg.spi_count == 4'h1) begin
            events[gpio_function_config_pkg::EVT_SPI_DONE] = 1'b1;
          end
        end
      end
      default: state_next.spi_state = SPI_IDLE;
    endcase
    // disabling aborts any transfer in flight
    if (!spi_on) begin
      state_next.spi_state = SPI_IDLE;
      state_next.spi_count = '0;
    end

    // ----------------------------------------------------------
    // pad muxing with overrides
    // ----------------------------------------------------------
    state_next.pads = decoded;
    if (state_reg.cfg_b[gpio_function_config_pkg::CONV_DONE_ENABLE_BIT]) begin
      state_next.pads[0] = '0;
      state_next.pads[0].out = state_reg.conv_done_n;
    end
    if (state_reg.control[gpio_function_config_pkg::BALANCE_ENABLE_BIT]) begin
      state_next.pads[2] = '0;
      state_next.pads[2].out = BALANCE_DRIVE_I;
    end
    // spi pins: 4 sclk, 5 miso, 6 mosi, 7 chip select
    if (spi_on) begin
      state_next.pads[3] = '0;
      state_next.pads[3].out = state_reg.spi_sclk;
      state_next.pads[4] = '0;
      state_next.pads[4].oe_n = 1'b1;
      state_next.pads[4].digital_in_en = 1'b1;
      state_next.pads[5] = '0;
      state_next.pads[5].out = state_reg.spi_shift[7];
      state_next.pads[6] = '0;
      state_next.pads[6].out = state_reg.spi_cs_n;
    end
    // fault input on pin 8 / plain pin 8
    state_next.alarm_n = 1'b1;
    if (state_reg.cfg_a[gpio_function_config_pkg::FAULT_IN_ENABLE_BIT]) begin
      state_next.pads[7] = '0;
      state_next.pads[7].oe_n = 1'b1;
      state_next.pads[7].digital_in_en = 1'b1;
      state_next.alarm_n = pin_sync[7];
      events[gpio_function_config_pkg::EVT_FAULT_IN] = !pin_sync[7];
    end

    // ----------------------------------------------------------
    // interrupts: read clears, a new event wins over the clear
    // ----------------------------------------------------------
    if (rd && index == gpio_function_config_pkg::EVENT_STATUS_INDEX) begin
      // only bits already reported are cleared, so a late event is not lost
      state_next.status = (state_reg.status & ~state_reg.prdata[2:0]) | events;
    end else begin
      state_next.status = state_reg.status | events;
    end
    state_next.irq = |(state_next.status & state_reg.mask);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_reg <= '0;
      state_reg.conv_done_n <= 1'b1;
      state_reg.spi_cs_n <= 1'b1;
      state_reg.alarm_n <= 1'b1;
      state_reg.pads <= {8{7'b010_0000}};
      state_reg.spi_state <= SPI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < gpio_function_config_pkg::NUM_PINS; i++) begin
      PIN_OUT_O[i] = state_reg.pads[i].out;
      PIN_OE_N_O[i] = state_reg.pads[i].oe_n;
      PIN_PULL_UP_O[i] = state_reg.pads[i].pull_up;
      PIN_PULL_DOWN_O[i] = state_reg.pads[i].pull_down;
      PIN_ANALOG_EN_O[i] = state_reg.pads[i].analog_en;
      PIN_TEMP_CMP_EN_O[i] = state_reg.pads[i].temp_cmp_en;
      PIN_DIGITAL_IN_EN_O[i] = state_reg.pads[i].digital_in_en;
    end
  end

  assign PRDATA_O = state_reg.prdata;
  assign PREADY_O = state_reg.pready;
  assign PSLVERR_O = state_reg.pslverr;
  assign ALARM_OUTPUT_N_O = state_reg.alarm_n;
  assign IRQ_O = state_reg.irq;
endmodule : gpio_function_config
`default_nettype wire

/* File: verification/gpio_function_config_props.sv */
`timescale 1ns/100ps
`default_nettype none
module gpio_function_config_checker (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // apb
  input wire logic [15:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // pins and events
  input wire logic CONV_DONE_I,
  input wire logic [7:0] PIN_IN_I,
  input wire logic [7:0] PIN_OUT_O,
  input wire logic [7:0] PIN_OE_N_O,
  input wire logic [7:0] PIN_PULL_UP_O,
  input wire logic [7:0] PIN_ANALOG_EN_O,
  input wire logic [7:0] PIN_DIGITAL_IN_EN_O,
  input wire logic ALARM_OUTPUT_N_O
);
  localparam logic [15:0] CFG_A = gpio_function_config_pkg::PIN_CONFIG_A_INDEX << 2;
  localparam logic [15:0] CFG_B = gpio_function_config_pkg::PIN_CONFIG_B_INDEX << 2;
  localparam logic [15:0] UPPER = gpio_function_config_pkg::CURRENT_RESULT_UPPER_INDEX << 2;
  // ----------
  // shadow of the configuration, so checks follow what software wrote
  // ----------
  logic [7:0] cfg_a_reg;
  logic [7:0] cfg_b_reg;
  logic take;
  logic rd_hi;
  assign take = PSEL_I && PENABLE_I && PREADY_O && !PSLVERR_O;
  assign rd_hi = take && !PWRITE_I && PADDR_I == UPPER;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cfg_a_reg <= 8'h00;
      cfg_b_reg <= 8'h00;
    end else if (take && PWRITE_I) begin
      if (PADDR_I == CFG_A) cfg_a_reg <= PWDATA_I[7:0];
      if (PADDR_I == CFG_B) cfg_b_reg <= PWDATA_I[7:0];
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  a_fault_alarm: assert property ((cfg_a_reg[7] && !PIN_IN_I[7]) [*4] |-> !ALARM_OUTPUT_N_O)
    else $error("alarm not raised");
  a_fault_off: assert property ((!cfg_a_reg[7]) [*3] |-> ALARM_OUTPUT_N_O)
    else $error("alarm without fault input");
  a_spi_pins: assert property (cfg_a_reg[6] [*2] |-> !PIN_OE_N_O[5] && PIN_OE_N_O[4])
    else $error("serial pins not taken over");
  a_high_z: assert property (cfg_a_reg[5:3] == 3'h0 |=> PIN_OE_N_O[1] && !PIN_ANALOG_EN_O[1])
    else $error("pin not idle");
  a_drive_high: assert property (cfg_a_reg[5:3] == 3'h4 |=> !PIN_OE_N_O[1] && PIN_OUT_O[1])
    else $error("pin not driven high");
  a_drive_low: assert property (cfg_a_reg[5:3] == 3'h5 |=> !PIN_OE_N_O[1] && !PIN_OUT_O[1])
    else $error("pin not driven low");
  a_weak_pullup: assert property (cfg_a_reg[5:3] == 3'h6 |=> PIN_PULL_UP_O[1])
    else $error("pull-up missing");
  a_pin1_field: assert property (!cfg_b_reg[6] && cfg_a_reg[2:0] == 3'h3 |=> PIN_DIGITAL_IN_EN_O[0])
    else $error("pin 1 ignores its field");
  a_conv_low: assert property (cfg_b_reg[6] && $rose(CONV_DONE_I) |-> ##2 !PIN_OUT_O[0])
    else $error("done strobe missing");
  a_conv_clear: assert property (cfg_b_reg[6] && rd_hi && !$rose(CONV_DONE_I) |-> ##2 PIN_OUT_O[0])
    else $error("done strobe not cleared");
  c_fault: cover property (!ALARM_OUTPUT_N_O);
  c_conv: cover property (cfg_b_reg[6] && $rose(CONV_DONE_I));
  c_spi: cover property (cfg_a_reg[6] && !PIN_OUT_O[6]);
endmodule : gpio_function_config_checker
bind gpio_function_config gpio_function_config_checker u_gpio_function_config_checker (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PADDR_I(PADDR_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .CONV_DONE_I(CONV_DONE_I), .PIN_IN_I(PIN_IN_I),
  .PIN_OUT_O(PIN_OUT_O), .PIN_OE_N_O(PIN_OE_N_O), .PIN_PULL_UP_O(PIN_PULL_UP_O),
  .PIN_ANALOG_EN_O(PIN_ANALOG_EN_O), .PIN_DIGITAL_IN_EN_O(PIN_DIGITAL_IN_EN_O),
  .ALARM_OUTPUT_N_O(ALARM_OUTPUT_N_O)
);
`default_nettype wire

/* File: verification/pin_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  // clock
  input wire logic clk_i,
  // pad controls
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pull_up_i,
  input wire logic [7:0] pull_down_i,
  // external sources
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] reply_i,
  // pad levels
  output logic [7:0] level_o
);
  logic float_reg = 1'b0;
  logic miso_reg = 1'b0;
  logic [7:0] mosi_reg = 8'h00;
  logic sclk_prev = 1'b0;
  logic cs_prev = 1'b0;
  logic cs_on;
  int bit_count = 0;
  assign cs_on = !oe_n_i[6] && !out_i[6];
  always @(posedge clk_i) float_reg <= ~float_reg;
  // mode 0 peripheral: samples on the rising clock, changes on the falling one
  always @(posedge clk_i) begin
    sclk_prev <= out_i[3];
    cs_prev <= cs_on;
    if (cs_on && !cs_prev) begin
      bit_count <= 0;
      miso_reg <= reply_i[7];
    end else if (cs_on && !sclk_prev && out_i[3]) begin
      mosi_reg <= {mosi_reg[6:0], out_i[5]};
    end else if (cs_on && sclk_prev && !out_i[3]) begin
      bit_count <= bit_count + 1;
      if (bit_count < 7) miso_reg <= reply_i[6 - bit_count];
    end
  end
  // undriven lines toggle so a stale level never passes for a real one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) level_o[i] = out_i[i];
      else if (i == 4 && cs_on) level_o[i] = miso_reg;
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pull_up_i[i]) level_o[i] = 1'b1;
      else if (pull_down_i[i]) level_o[i] = 1'b0;
      else level_o[i] = float_reg ^ i[0];
    end
  end
endmodule : pin_partner
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [15:0] CFG_A = gpio_function_config_pkg::PIN_CONFIG_A_INDEX << 2;
  localparam logic [15:0] CFG_B = gpio_function_config_pkg::PIN_CONFIG_B_INDEX << 2;
  localparam logic [15:0] CFG_C = gpio_function_config_pkg::PIN_CONFIG_C_INDEX << 2;
  localparam logic [15:0] CFG_D = gpio_function_config_pkg::PIN_CONFIG_D_INDEX << 2;
  localparam logic [15:0] UPPER = gpio_function_config_pkg::CURRENT_RESULT_UPPER_INDEX << 2;
  localparam logic [15:0] STATUS = gpio_function_config_pkg::EVENT_STATUS_INDEX << 2;
  localparam logic [15:0] MASK = gpio_function_config_pkg::EVENT_MASK_INDEX << 2;
  localparam logic [15:0] SPI = gpio_function_config_pkg::SPI_DATA_INDEX << 2;
  localparam logic [15:0] CTRL = gpio_function_config_pkg::CONTROL_INDEX << 2;
  logic balance = 1'b0;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic conv_done = 1'b0;
  logic [15:0] current_result = 16'h0000;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, err, alarm_output_n, irq;
  logic [7:0] pin_in, pin_out, pin_oe_n, pull_up, pull_down, analog_en, temp_cmp_en, dig_en;
  logic [6:0] pad_tab [8] = '{7'h20, 7'h26, 7'h24, 7'h21, 7'h40, 7'h00, 7'h34, 7'h2C};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  gpio_function_config u_gpio_function_config (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CONV_DONE_I(conv_done), .CURRENT_RESULT_I(current_result),
    .BALANCE_DRIVE_I(balance), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n),
    .PIN_PULL_UP_O(pull_up), .PIN_PULL_DOWN_O(pull_down), .PIN_ANALOG_EN_O(analog_en),
    .PIN_TEMP_CMP_EN_O(temp_cmp_en), .PIN_DIGITAL_IN_EN_O(dig_en),
    .ALARM_OUTPUT_N_O(alarm_output_n), .IRQ_O(irq)
  );
  pin_partner u_pin_partner (
    .clk_i(sys_clk), .out_i(pin_out), .oe_n_i(pin_oe_n), .pull_up_i(pull_up),
    .pull_down_i(pull_down), .ext_en_i(ext_en), .ext_val_i(ext_val), .reply_i(8'h3C),
    .level_o(pin_in)
  );
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("wrong value at %0t: run hung", $time);
      test_done();
    end
  end
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // ready and data are taken at the rising edge that completes the access
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h00_0000, d});
  endtask : wr
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask : settle
  task automatic pulse;
    @(posedge sys_clk);
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
  endtask : pulse
  function automatic logic [6:0] pad(input int i);
    return {pin_out[i], pin_oe_n[i], pull_up[i], pull_down[i], analog_en[i], temp_cmp_en[i],
      dig_en[i]};
  endfunction : pad
  // ----------
  // scenarios
  // ----------
  task automatic t_reset;
    chk(pin_oe_n, 8'hFF);
    chk(alarm_output_n, 1'b1);
    apb(CFG_A, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    wr(CFG_B, 8'hFF);
    apb(CFG_B, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_007F);
    wr(CFG_B, 8'h00);
    apb(16'h0004, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
  endtask : t_reset
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      wr(CFG_A, {2'b00, 3'(7 - c), 3'(c)});
      settle();
      chk(pad(0), pad_tab[c]);
      chk(pad(1), pad_tab[7 - c]);
    end
  endtask : t_codes
  task automatic t_fault;
    @(posedge sys_clk);
    ext_en <= 8'h80;
    wr(CFG_D, 8'h20);
    settle();
    chk(pad(7), pad_tab[4]);
    chk(alarm_output_n, 1'b1);
    wr(MASK, 8'hFF);
    wr(CFG_A, 8'h80);
    settle();
    settle();
    chk({pin_oe_n[7], alarm_output_n, irq}, 3'b101);
    wr(MASK, 8'h00);
    settle();
    chk(irq, 1'b0);
    @(posedge sys_clk);
    ext_val <= 8'h80;
    settle();
    settle();
    chk(alarm_output_n, 1'b1);
    wr(MASK, 8'hFF);
    settle();
    chk(irq, 1'b1);
    apb(STATUS, 1'b0, 32'h0000_0000);
    chk(rdata[1], 1'b1);
    settle();
    chk(irq, 1'b0);
    wr(CFG_A, 8'h00);
  endtask : t_fault
  task automatic t_conv;
    wr(CFG_A, 8'h04);
    current_result <= 16'hA53C;
    pulse();
    settle();
    chk(pad(0), pad_tab[4]);
    wr(CFG_B, 8'h40);
    pulse();
    settle();
    chk({pin_oe_n[0], pin_out[0]}, 2'b00);
    apb(UPPER, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_00A5);
    settle();
    chk({pin_oe_n[0], pin_out[0]}, 2'b01);
    wr(CFG_B, 8'h00);
    settle();
    chk(pad(0), pad_tab[4]);
  endtask : t_conv
  task automatic t_spi;
    wr(CFG_C, 8'h04);
    wr(CFG_A, 8'h40);
    settle();
    chk(pin_oe_n[5:3], 3'b010);
    wr(SPI, 8'hA5);
    for (int k = 0; k < 400 && u_pin_partner.bit_count != 8; k++) @(negedge sys_clk);
    for (int k = 0; k < 40 && pin_out[6] !== 1'b1; k++) @(negedge sys_clk);
    chk(pin_out[6], 1'b1);
    chk(u_pin_partner.mosi_reg, 8'hA5);
    apb(STATUS, 1'b0, 32'h0000_0000);
    chk(rdata[2], 1'b1);
    apb(SPI, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_003C);
    wr(CFG_A, 8'h00);
    settle();
    chk(pin_oe_n[4], 1'b0);
  endtask : t_spi
  task automatic t_bal;
    wr(CTRL, 8'h01);
    balance <= 1'b1;
    settle();
    chk(pad(2), pad_tab[4]);
    wr(CTRL, 8'h00);
    balance <= 1'b0;
    settle();
    chk(pad(2), pad_tab[0]);
  endtask : t_bal
  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_codes();
    t_fault();
    t_conv();
    t_spi();
    t_bal();
    test_done();
  end
endmodule : tb
`default_nettype wire
